// File: design/tdc_defs.vh
`ifndef TDC_DEFS_VH
`define TDC_DEFS_VH

// apb register byte offsets
`define TDC_REG_CTRL 8'h00
`define TDC_REG_BASE 8'h04
`define TDC_REG_LAST 8'h08
`define TDC_REG_CUR 8'h0c
`define TDC_REG_STAT 8'h10

// control register bits
`define TDC_CTRL_START 0
`define TDC_CTRL_POLL 1
`define TDC_CTRL_LEC 2
`define TDC_CTRL_BE 3

// first descriptor word layout
`define TDC_FE_BIT 31
`define TDC_HOLD_BIT 30
`define TDC_HI_BIT 29
`define TDC_NO_W 16

// fourth descriptor word: complete flag position
`define TDC_CPL_BIT 30

// descriptor geometry in memory
`define TDC_DESC_WORDS 4'h3
`define TDC_POLL_WORDS 4'h2
`define TDC_CPL_OFS 32'h0000000c
`define TDC_MAX_BURST 4'hf
`define TDC_WORD_STEP 32'h00000004

`endif

// File: design/tdc_lane_map.v
`include "tdc_defs.vh"

module tdc_lane_map (
    input wire [31:0] word_in,
    input wire [1:0] start_in,
    input wire [`TDC_NO_W:0] bytes_in,
    input wire big_endian_in,
    output wire [31:0] data_out,
    output wire [3:0] mask_out,
    output wire [2:0] cnt_out
);
    wire [2:0] room;
    assign room = 3'h4 - {1'b0, start_in};
    // byte count may cut the first word short
    assign cnt_out = (bytes_in < {{(`TDC_NO_W - 2){1'b0}}, room}) ? bytes_in[2:0] : room;

    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_lane
            // sized copies of the lane index keep the lane sums at two bits
            localparam [2:0] KC = k;
            localparam [1:0] KL = KC[1:0];
            wire [1:0] le_lane;
            wire [1:0] be_lane;
            wire [1:0] lane;
            assign le_lane = start_in + KL;
            assign be_lane = 2'h3 - start_in - KL;
            assign lane = big_endian_in ? be_lane : le_lane;
            assign mask_out[k] = (KC < cnt_out);
            assign data_out[8 * k +: 8] = mask_out[k] ? word_in[8 * lane +: 8] : 8'h00;
        end
    endgenerate
endmodule // tdc_lane_map

// File: design/tdc_apb_regs.v
`include "tdc_defs.vh"

module tdc_apb_regs (
    input wire sys_clk_in,
    input wire srst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    output reg start_out,
    output reg poll_out,
    output reg lec_mode_out,
    output reg big_endian_out,
    output reg [31:0] base_out,
    output reg [31:0] last_out,
    input wire [31:0] cur_in,
    input wire [7:0] stat_in
);
    wire mapped;
    wire commit;
    reg [31:0] next_rdata;

    assign mapped = (paddr_in == `TDC_REG_CTRL) || (paddr_in == `TDC_REG_BASE) ||
                    (paddr_in == `TDC_REG_LAST) || (paddr_in == `TDC_REG_CUR) ||
                    (paddr_in == `TDC_REG_STAT);
    assign commit = psel_in & penable_in & pready_out;

    always @* begin
        next_rdata = 32'h00000000;
        case (paddr_in)
            `TDC_REG_CTRL: begin
                next_rdata[`TDC_CTRL_LEC] = lec_mode_out;
                next_rdata[`TDC_CTRL_BE] = big_endian_out;
            end
            `TDC_REG_BASE: next_rdata = base_out;
            `TDC_REG_LAST: next_rdata = last_out;
            `TDC_REG_CUR: next_rdata = cur_in;
            `TDC_REG_STAT: next_rdata = {24'h000000, stat_in};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // zero-wait slave: pready rises for the access phase only
    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            prdata_out <= 32'h00000000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            start_out <= 1'b0;
            poll_out <= 1'b0;
            lec_mode_out <= 1'b0;
            big_endian_out <= 1'b0;
            base_out <= 32'h00000000;
            last_out <= 32'h00000000;
        end else begin
            pready_out <= psel_in & ~penable_in;
            start_out <= 1'b0;
            poll_out <= 1'b0;
            if (psel_in & ~penable_in) begin
                prdata_out <= pwrite_in ? 32'h00000000 : next_rdata;
                pslverr_out <= ~mapped;
            end
            if (commit & pwrite_in) begin
                case (paddr_in)
                    `TDC_REG_CTRL: begin
                        start_out <= pwdata_in[`TDC_CTRL_START];
                        poll_out <= pwdata_in[`TDC_CTRL_POLL];
                        lec_mode_out <= pwdata_in[`TDC_CTRL_LEC];
                        big_endian_out <= pwdata_in[`TDC_CTRL_BE];
                    end
                    `TDC_REG_BASE: base_out <= pwdata_in;
                    `TDC_REG_LAST: last_out <= pwdata_in;
                    default: ;
                endcase
            end
        end
    end
endmodule // tdc_apb_regs

// File: design/tdc_channel.v
// Behaviour
// - software loads first descriptor address; the walk starts there
// - first three descriptor words are fetched as one burst
// - frame-end flag is not list control; it travels with the data
// - completed descriptor with frame-end set pulses the frame-end interrupt
// - hold flag ends the chain; next pointer is not followed
// - poll re-reads hold flag and next pointer and decides again
// - in last-address mode the hold flag is ignored
// - host-interrupt flag pulses an interrupt after data and completion
// - words read follow from byte count and start offset
// - next descriptor is fetched from the second word's pointer
// - data read starts at third word's pointer, bursts of up to 15
// - fourth word is written with the complete flag after the data
// - a fifth descriptor word is never touched
// - data moves in burst-sized pieces while the fifo requests
// - complete first, then branch if list control allows
// - frame-end marker lets the serial controller close the frame
// - frame-end clear at hold or last address raises an error interrupt
// - two low pointer bits give the start offset
// - full-word reads with all byte enables; bad bytes masked inside
// - first word holds 4, 3, 2 or 1 bytes, cut by byte count
// - lane order rises in little endian, falls in big endian
// - descriptors are handled the same in every protocol mode
//
// The register addresses and the APB register port were left to the implementer.
`include "tdc_defs.vh"

module tdc_channel #(
    parameter FE_BIT = `TDC_FE_BIT,
    parameter HOLD_BIT = `TDC_HOLD_BIT,
    parameter HI_BIT = `TDC_HI_BIT
) (
    input wire sys_clk_in,
    input wire srst_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    output reg mem_req_out,
    output reg mem_we_out,
    output reg [31:0] mem_addr_out,
    output reg [3:0] mem_len_out,
    output reg [31:0] mem_wdata_out,
    output reg [3:0] mem_be_out,
    input wire mem_ack_in,
    input wire mem_rvalid_in,
    input wire [31:0] mem_rdata_in,
    input wire fifo_req_in,
    output reg fifo_wr_out,
    output reg [31:0] fifo_data_out,
    output reg [3:0] fifo_bmask_out,
    output reg fifo_fe_out,
    output reg frame_end_irq_out,
    output reg host_irq_out,
    output reg err_irq_out
);
    localparam S_IDLE = 4'h0;
    localparam S_DREQ = 4'h1;
    localparam S_DRX = 4'h2;
    localparam S_EVAL = 4'h3;
    localparam S_FWAIT = 4'h4;
    localparam S_FREQ = 4'h5;
    localparam S_FRX = 4'h6;
    localparam S_CWR = 4'h7;
    localparam S_HOLD = 4'h8;

    localparam NW = `TDC_NO_W;

    reg [3:0] state;
    reg [31:0] cur;
    reg [31:0] w1;
    reg [31:0] nxt;
    reg [31:0] bptr;
    reg [31:0] rd_ptr;
    reg [NW+1:0] words_left;
    reg [NW:0] bytes_left;
    reg [3:0] beat;
    reg first;
    reg is_poll;

    wire start_pulse;
    wire poll_pulse;
    wire lec_mode;
    wire big_endian;
    wire [31:0] base_addr;
    wire [31:0] last_tx_desc_addr;
    wire [31:0] current_tx_desc_addr;
    wire [31:0] lane_data;
    wire [3:0] lane_mask;
    wire [2:0] lane_cnt;
    wire frame_end_flag;
    wire hold_flag;
    wire host_irq_request_flag;
    wire at_last;
    wire stop_here;
    wire [NW+1:0] calc_words;
    wire [3:0] burst_len;
    wire [1:0] start_ofs;

    assign current_tx_desc_addr = cur;
    assign frame_end_flag = w1[FE_BIT];
    // hold has no effect in last-address mode
    assign hold_flag = w1[HOLD_BIT] & ~lec_mode;
    assign host_irq_request_flag = w1[HI_BIT];
    assign at_last = lec_mode & (cur == last_tx_desc_addr);
    // chain end by hold or last address
    assign stop_here = hold_flag | at_last;
    // words from offset plus byte count, rounded up
    // zero bytes reads nothing, whatever the start offset
    assign calc_words = (w1[NW-1:0] == {NW{1'b0}}) ? {(NW + 2){1'b0}} :
                        (({2'b00, w1[NW-1:0]} + {{NW{1'b0}}, bptr[1:0]} +
                          {{NW{1'b0}}, 2'h3}) >> 2);
    // pieces no longer than fifteen words
    assign burst_len = (words_left > {{(NW - 2){1'b0}}, `TDC_MAX_BURST}) ?
                       `TDC_MAX_BURST : words_left[3:0];
    // offset applies to the first word only
    assign start_ofs = first ? bptr[1:0] : 2'b00;

    tdc_apb_regs u_regs (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out),
        .start_out(start_pulse),
        .poll_out(poll_pulse),
        .lec_mode_out(lec_mode),
        .big_endian_out(big_endian),
        .base_out(base_addr),
        .last_out(last_tx_desc_addr),
        .cur_in(current_tx_desc_addr),
        .stat_in({state, 2'b00, state == S_HOLD, state != S_IDLE})
    );

    // byte lanes, mask and valid byte count of each data word
    tdc_lane_map u_lane (
        .word_in(mem_rdata_in),
        .start_in(start_ofs),
        .bytes_in(bytes_left),
        .big_endian_in(big_endian),
        .data_out(lane_data),
        .mask_out(lane_mask),
        .cnt_out(lane_cnt)
    );

    always @(posedge sys_clk_in) begin
        if (srst_in) begin
            state <= S_IDLE;
            cur <= 32'h00000000;
            w1 <= 32'h00000000;
            nxt <= 32'h00000000;
            bptr <= 32'h00000000;
            rd_ptr <= 32'h00000000;
            words_left <= {(NW + 2){1'b0}};
            bytes_left <= {(NW + 1){1'b0}};
            beat <= 4'h0;
            first <= 1'b0;
            is_poll <= 1'b0;
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= 32'h00000000;
            mem_len_out <= 4'h0;
            mem_wdata_out <= 32'h00000000;
            mem_be_out <= 4'hf;
            fifo_wr_out <= 1'b0;
            fifo_data_out <= 32'h00000000;
            fifo_bmask_out <= 4'h0;
            fifo_fe_out <= 1'b0;
            frame_end_irq_out <= 1'b0;
            host_irq_out <= 1'b0;
            err_irq_out <= 1'b0;
        end else begin
            fifo_wr_out <= 1'b0;
            fifo_fe_out <= 1'b0;
            frame_end_irq_out <= 1'b0;
            host_irq_out <= 1'b0;
            err_irq_out <= 1'b0;
            // every access uses all byte lanes
            mem_be_out <= 4'hf;
            case (state)
                S_IDLE: begin
                    // walk begins at the loaded base
                    if (start_pulse) begin
                        cur <= base_addr;
                        is_poll <= 1'b0;
                        state <= S_DREQ;
                    end
                end
                S_DREQ: begin
                    // one burst for the host-written words
                    // a poll re-reads only words one and two
                    mem_we_out <= 1'b0;
                    mem_addr_out <= cur;
                    mem_len_out <= is_poll ? `TDC_POLL_WORDS : `TDC_DESC_WORDS;
                    mem_req_out <= ~(mem_req_out & mem_ack_in);
                    if (mem_req_out & mem_ack_in) begin
                        beat <= 4'h0;
                        state <= S_DRX;
                    end
                end
                S_DRX: begin
                    if (mem_rvalid_in) begin
                        beat <= beat + 4'h1;
                        case (beat)
                            4'h0: w1 <= mem_rdata_in;
                            4'h1: nxt <= mem_rdata_in;
                            default: bptr <= mem_rdata_in;
                        endcase
                        if (beat == mem_len_out - 4'h1) begin
                            state <= S_EVAL;
                        end
                    end
                end
                S_EVAL: begin
                    if (is_poll) begin
                        is_poll <= 1'b0;
                        if (stop_here) begin
                            state <= S_HOLD;
                        end else begin
                            cur <= nxt;
                            state <= S_DREQ;
                        end
                    end else begin
                        // frame not closed at chain end
                        err_irq_out <= ~frame_end_flag & stop_here;
                        words_left <= calc_words;
                        bytes_left <= w1[NW:0] & {1'b0, {NW{1'b1}}};
                        // reads start at the buffer pointer word
                        rd_ptr <= {bptr[31:2], 2'b00};
                        first <= 1'b1;
                        state <= (calc_words == {(NW + 2){1'b0}}) ? S_CWR : S_FWAIT;
                    end
                end
                S_FWAIT: begin
                    // only while the fifo asks for data
                    if (fifo_req_in) begin
                        mem_we_out <= 1'b0;
                        mem_addr_out <= rd_ptr;
                        mem_len_out <= burst_len;
                        mem_req_out <= 1'b1;
                        state <= S_FREQ;
                    end
                end
                S_FREQ: begin
                    if (mem_ack_in) begin
                        mem_req_out <= 1'b0;
                        beat <= mem_len_out;
                        state <= S_FRX;
                    end
                end
                S_FRX: begin
                    if (mem_rvalid_in) begin
                        fifo_wr_out <= 1'b1;
                        fifo_data_out <= lane_data;
                        fifo_bmask_out <= lane_mask;
                        // flag forwarded on the last word
                        // marker lets the serial side close the frame
                        fifo_fe_out <= frame_end_flag & (words_left == 1);
                        bytes_left <= bytes_left - {{(NW - 2){1'b0}}, lane_cnt};
                        words_left <= words_left - 1'b1;
                        rd_ptr <= rd_ptr + `TDC_WORD_STEP;
                        first <= 1'b0;
                        beat <= beat - 4'h1;
                        if (words_left == 1) begin
                            state <= S_CWR;
                        end else if (beat == 4'h1) begin
                            state <= S_FWAIT;
                        end
                    end
                end
                S_CWR: begin
                    // complete flag into the fourth word
                    // offset twelve only, never the fifth word
                    mem_we_out <= 1'b1;
                    mem_addr_out <= cur + `TDC_CPL_OFS;
                    mem_len_out <= 4'h1;
                    mem_wdata_out <= 32'h00000001 << `TDC_CPL_BIT;
                    mem_req_out <= ~(mem_req_out & mem_ack_in);
                    if (mem_req_out & mem_ack_in) begin
                        mem_we_out <= 1'b0;
                        // same handling in every protocol mode
                        frame_end_irq_out <= frame_end_flag;
                        // host-requested interrupt after data and completion
                        host_irq_out <= host_irq_request_flag;
                        if (stop_here) begin
                            state <= S_HOLD;
                        end else begin
                            // next address from the second word
                            cur <= nxt;
                            state <= S_DREQ;
                        end
                    end
                end
                S_HOLD: begin
                    if (start_pulse) begin
                        cur <= base_addr;
                        is_poll <= 1'b0;
                        state <= S_DREQ;
                    end else if (poll_pulse) begin
                        is_poll <= 1'b1;
                        state <= S_DREQ;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule // tdc_channel

// File: testbench/tdc_channel_chk.sv
`include "tdc_defs.vh"
module tdc_channel_chk (
    input logic sys_clk_in,
    input logic srst_in,
    input logic psel_in,
    input logic penable_in,
    input logic pready_out,
    input logic mem_req_out,
    input logic mem_we_out,
    input logic [31:0] mem_addr_out,
    input logic [3:0] mem_len_out,
    input logic [31:0] mem_wdata_out,
    input logic [3:0] mem_be_out,
    input logic mem_ack_in,
    input logic fifo_wr_out,
    input logic [3:0] fifo_bmask_out,
    input logic fifo_fe_out,
    input logic frame_end_irq_out,
    input logic host_irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    a_be_all_on: assert property (mem_be_out == 4'hf)
        else $error("byte enables narrowed");
    a_word_addr: assert property (mem_req_out |-> mem_addr_out[1:0] == 2'b00)
        else $error("memory access not word aligned");
    a_req_held: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
        && $stable(mem_addr_out) && $stable(mem_len_out) && $stable(mem_we_out))
        else $error("memory request changed before ack");
    a_req_drop: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
        else $error("memory request not dropped after ack");
    a_read_len: assert property (mem_req_out && !mem_we_out |-> mem_len_out inside {[1:15]})
        else $error("read burst length out of range");
    a_cpl_word: assert property (mem_req_out && mem_we_out
        |-> mem_len_out == 4'h1 && mem_wdata_out[`TDC_CPL_BIT])
        else $error("completion write malformed");
    a_fe_on_word: assert property (fifo_fe_out |-> fifo_wr_out)
        else $error("frame end marker without data word");
    a_fi_after_cpl: assert property (frame_end_irq_out
        |-> $past(mem_req_out && mem_ack_in && mem_we_out))
        else $error("frame end interrupt not after completion");
    a_hi_after_cpl: assert property (host_irq_out
        |-> $past(mem_req_out && mem_ack_in && mem_we_out))
        else $error("host interrupt not after completion");
    a_mask_low: assert property (fifo_wr_out |-> fifo_bmask_out inside {1, 3, 7, 15})
        else $error("byte mask not contiguous from byte zero");
    a_apb_wait: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("apb ready not a single access cycle");
endmodule // tdc_channel_chk

bind tdc_channel tdc_channel_chk u_chk (.sys_clk_in, .srst_in, .psel_in, .penable_in,
    .pready_out, .mem_req_out, .mem_we_out, .mem_addr_out, .mem_len_out, .mem_wdata_out,
    .mem_be_out, .mem_ack_in, .fifo_wr_out, .fifo_bmask_out, .fifo_fe_out,
    .frame_end_irq_out, .host_irq_out);

// File: testbench/tdc_mem_model.sv
module tdc_mem_model (
    input logic sys_clk_in,
    input logic srst_in,
    input logic slow_in,
    input logic req_in,
    input logic we_in,
    input logic [31:0] addr_in,
    input logic [3:0] len_in,
    input logic [31:0] wdata_in,
    output logic ack_out,
    output logic rvalid_out,
    output logic [31:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:4095];
    logic [31:0] ra = 0;
    int beats = 0;
    int dly = 0;
    initial ack_out = 1'b0;
    initial rvalid_out = 1'b0;
    initial rdata_out = 32'h0;
    always @(posedge sys_clk_in) begin
        ack_out <= 1'b0;
        rvalid_out <= 1'b0;
        // idle data flips so a stale beat never looks valid
        rdata_out <= ~rdata_out;
        if (srst_in) begin
            beats = 0;
            dly = 0;
        end else if (dly > 0) begin
            dly--;
        end else if (beats > 0) begin
            rvalid_out <= 1'b1;
            rdata_out <= mem[ra[13:2]];
            ra += 32'h4;
            beats--;
            dly = slow_in ? $urandom % 3 : 0;
        end else if (ack_out && req_in) begin
            // only the addressed word is written
            if (we_in) mem[addr_in[13:2]] <= wdata_in;
            beats = we_in ? 0 : len_in;
            ra = addr_in;
            dly = slow_in ? $urandom % 3 : 0;
        end else if (req_in) begin
            ack_out <= 1'b1;
        end
    end
endmodule // tdc_mem_model

// File: testbench/tx_descriptor_dma_channel_tb.sv
`include "tdc_defs.vh"
module tx_descriptor_dma_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, freq = 0, slow = 0, rerr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, maddr, mwd, mrd, fdata, r;
    logic pready, pslverr, mreq, mwe, mack, mrv, fwr, ffe, fi, hi, er;
    logic [3:0] mlen, mbe, fmask;
    int err_total = 0, compares = 0, cycles = 0, n_fi = 0, n_hi = 0, n_er = 0, n_fe = 0;
    int n_cpl = 0, e_fi = 0, e_hi = 0, e_er = 0, e_fe = 0, e_cpl = 0;
    logic [7:0] got[$], exp[$];
    int dq[$];
    always #2.5 clk = ~clk;
    tdc_channel dut (.sys_clk_in(clk), .srst_in(srst), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .mem_req_out(mreq), .mem_we_out(mwe),
        .mem_addr_out(maddr), .mem_len_out(mlen), .mem_wdata_out(mwd), .mem_be_out(mbe),
        .mem_ack_in(mack), .mem_rvalid_in(mrv), .mem_rdata_in(mrd), .fifo_req_in(freq),
        .fifo_wr_out(fwr), .fifo_data_out(fdata), .fifo_bmask_out(fmask), .fifo_fe_out(ffe),
        .frame_end_irq_out(fi), .host_irq_out(hi), .err_irq_out(er));
    tdc_mem_model mem (.sys_clk_in(clk), .srst_in(srst), .slow_in(slow), .req_in(mreq),
        .we_in(mwe), .addr_in(maddr), .len_in(mlen), .wdata_in(mwd), .ack_out(mack),
        .rvalid_out(mrv), .rdata_out(mrd));
    task automatic test_done();
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        freq <= ($urandom % 4) != 0;
        if (fwr === 1'b1) begin
            for (int k = 0; k < 4; k++) if (fmask[k]) got.push_back(fdata[8*k+:8]);
        end
        n_fi += (fi === 1'b1);
        n_hi += (hi === 1'b1);
        n_er += (er === 1'b1);
        n_fe += (ffe === 1'b1);
        n_cpl += ((mreq && mack && mwe) === 1'b1);
        if (cycles == 60000) begin
            err_total++;
            test_done();
        end
    end
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // eight-word stride keeps descriptors reusable
    task automatic desc(int d, int nxt, int bp, int n, bit fe, bit hd, bit hq, bit be);
        logic [31:0] w = 0;
        w[`TDC_NO_W-1:0] = n;
        w[`TDC_FE_BIT] = fe;
        w[`TDC_HOLD_BIT] = hd;
        w[`TDC_HI_BIT] = hq;
        mem.mem[d/4] = w;
        mem.mem[d/4+1] = nxt;
        mem.mem[d/4+2] = bp;
        mem.mem[d/4+3] = 0;
        mem.mem[d/4+4] = 32'h5a5a5a5a;
        for (int i = 0; i < n; i++)
            exp.push_back(mem.mem[(bp+i)/4][8*(be ? 3-(bp+i)%4 : (bp+i)%4)+:8]);
        e_fe += fe;
        e_fi += fe;
        e_hi += hq;
        e_cpl++;
        dq.push_back(d);
    endtask
    task automatic go(logic [31:0] ctl, int last);
        apb(1, `TDC_REG_CTRL, ctl);
        r = 0;
        for (int i = 0; i < 400 && !(r[1] === 1'b1 && n_cpl == e_cpl); i++)
            apb(0, `TDC_REG_STAT, 0);
        chk("cpl_count", e_cpl, n_cpl);
        apb(0, `TDC_REG_CUR, 0);
        chk("cur_desc", last, r);
        chk("byte_count", exp.size(), got.size());
        foreach (exp[i]) chk("data_byte", exp[i], got[i]);
        chk("fe_marks", e_fe, n_fe);
        chk("fi_irqs", e_fi, n_fi);
        chk("hi_irqs", e_hi, n_hi);
        chk("err_irqs", e_er, n_er);
        foreach (dq[i]) chk("cpl_bit", 1, mem.mem[dq[i]/4+3][`TDC_CPL_BIT]);
        foreach (dq[i]) chk("word_five", 32'h5a5a5a5a, mem.mem[dq[i]/4+4]);
        exp.delete();
        got.delete();
        dq.delete();
    endtask
    initial begin
        int b, nd, fe, lec, be;
        void'($urandom(32'h2f5df03a));
        foreach (mem.mem[i]) mem.mem[i] = $urandom;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        apb(0, 8'h14, 0);
        chk("unmapped_err", 1, rerr);
        apb(0, `TDC_REG_STAT, 0);
        chk("stat_idle", 0, r[1:0]);
        for (int t = 0; t < 8; t++) begin
            be = t % 2;
            lec = (t / 2) % 2;
            slow <= t > 3;
            nd = 1 + $urandom % 3;
            b = 32'h1000 + t * 32'h100;
            for (int k = 0; k < nd; k++) begin
                fe = (k == nd - 1) || ($urandom % 2);
                // hold set at random while last-address mode ignores it
                desc(b + k*32, b + (k+1)*32, 32'h2000 + t*32'h400 + k*32'h80 + $urandom % 4,
                    1 + $urandom % 40, fe, lec ? $urandom % 2 : k == nd - 1, $urandom % 2, be);
            end
            apb(1, `TDC_REG_BASE, b);
            apb(1, `TDC_REG_LAST, b + (nd-1)*32);
            go({28'h0, be[0], lec[0], 2'b01}, b + (nd-1)*32);
        end
        desc(32'h1800, 32'h1820, 32'h3e01, 9, 1, 1, 0, 0);
        apb(1, `TDC_REG_BASE, 32'h1800);
        go(32'h1, 32'h1800);
        mem.mem[32'h1800/4][`TDC_HOLD_BIT] = 1'b0;
        // long buffer forces a fifteen-word burst and a short tail
        desc(32'h1820, 32'h1840, 32'h3e43, 70, 1, 1, 1, 0);
        go(32'h2, 32'h1820);
        desc(32'h1900, 32'h1920, 32'h3f02, 6, 0, 1, 0, 0);
        e_er++;
        apb(1, `TDC_REG_BASE, 32'h1900);
        go(32'h1, 32'h1900);
        desc(32'h1940, 32'h1960, 32'h3f42, 5, 0, 0, 0, 0);
        e_er++;
        apb(1, `TDC_REG_BASE, 32'h1940);
        apb(1, `TDC_REG_LAST, 32'h1940);
        go(32'h5, 32'h1940);
        test_done();
    end
endmodule // tx_descriptor_dma_channel_tb
